// file: dv/bfim_host_model.sv
`timescale 1ns/1ps
module bfim_host_model
    import bfim_pkg::*;
(
    input  wire logic       mclk_in,       // system clock
    output logic      [7:0] reg_addr_out,  // register address
    output logic            reg_wr_out,    // write strobe
    output logic      [7:0] reg_wdata_out, // write data
    output logic            reg_rd_out,    // read strobe
    input  wire logic [7:0] reg_rdata_in,  // read data
    input  wire logic       reg_rvalid_in  // read data valid
);
    initial
    begin
        {reg_wr_out, reg_rd_out} = 2'b00;
        {reg_addr_out, reg_wdata_out} = 16'h0000;
    end
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        #1;
        {reg_addr_out, reg_wdata_out, reg_wr_out} = {a, d, 1'b1};
        @(posedge mclk_in);
        #1;
        // idle bus shows no stale address or data
        {reg_addr_out, reg_wdata_out, reg_wr_out} = {~a, ~d, 1'b0};
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        #1;
        {reg_addr_out, reg_rd_out} = {a, 1'b1};
        @(posedge mclk_in);
        #1;
        {reg_addr_out, reg_rd_out} = {~a, 1'b0};
        d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 8'hXX;
    endtask : read_reg
    task automatic boot;
        logic [7:0] s;
        read_reg(BFIM_STATUS_ADDR, s);
        if (s[BFIM_SUPPLY_BIT] === 1'b1)
        begin
            write_reg(BFIM_MAP_ADDR, 8'h00);
            write_reg(BFIM_CLEAR_ADDR, 8'h01);
        end
    endtask : boot
endmodule : bfim_host_model

// file: dv/bfim_top_sva.sv
`timescale 1ns/1ps
module bfim_top_sva
    import bfim_pkg::*;
(
    input  wire logic        mclk_in,            // system clock
    input  wire logic        sys_rst_in,         // sync reset
    input  wire logic [7:0]  reg_addr_in,        // register address
    input  wire logic        reg_wr_in,          // write strobe
    input  wire logic [7:0]  reg_wdata_in,       // write data
    input  wire logic        reg_rd_in,          // read strobe
    input  wire logic [7:0]  reg_rdata_out,      // read data
    input  wire logic        reg_rvalid_out,     // read valid
    input  wire logic        supply_fail_in,     // supply failure
    input  wire logic        kbd_event_in,       // keyboard pending
    input  wire logic [2:0]  countdown_event_in, // countdown events
    input  wire logic [2:0]  cycle_event_in,     // cycle events
    input  wire logic        gio_event_in,       // general I/O pending
    input  wire logic [19:0] keypad_claim_in,    // keypad claims
    input  wire logic [19:0] keypad_oe_in,       // keypad drive enable
    input  wire logic [19:0] ball_out,           // ball level
    input  wire logic [19:0] ball_oe_n_out,      // ball drive, low
    input  wire logic [7:0]  status_out          // status byte
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    logic sel_q;
    // shadow of the write-only request select, the only way to see it
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            sel_q <= 1'b0;
        else if (reg_wr_in && reg_addr_in == BFIM_MAP_ADDR)
            sel_q <= reg_wdata_in[BFIM_REQ_SEL_BIT];
    end
    irq_assert_a: assert property ($past(sel_q) && $past(sel_q, 2) &&
        !$past(keypad_claim_in[19]) && $past(status_out) != 8'h00
        |-> !ball_oe_n_out[19] && !ball_out[19]) else $error("request ball not driven");
    irq_release_a: assert property ($past(sel_q) && $past(sel_q, 2) &&
        !$past(keypad_claim_in[19]) && $past(status_out) == 8'h00
        |-> ball_oe_n_out[19]) else $error("request ball driven while idle");
    supply_reset_a: assert property ($past(sys_rst_in)
        |-> status_out[BFIM_SUPPLY_BIT]) else $error("supply flag clear after reset");
    supply_set_a: assert property (supply_fail_in [*4]
        |-> ##[0:2] status_out[BFIM_SUPPLY_BIT]) else $error("supply failure not flagged");
    clear_one_a: assert property (!supply_fail_in [*4] ##0 (reg_wr_in &&
        reg_addr_in == BFIM_CLEAR_ADDR && reg_wdata_in[0])
        |=> !status_out[BFIM_SUPPLY_BIT]) else $error("supply flag not cleared");
    clear_zero_a: assert property (reg_wr_in && reg_addr_in == BFIM_CLEAR_ADDR &&
        !reg_wdata_in[0] && status_out[7] |=> status_out[7]) else $error("zero write cleared");
    event_map_a: assert property (!$past(sys_rst_in)
        |-> status_out[6:0] == $past({kbd_event_in, 2'b00,
        countdown_event_in | cycle_event_in, gio_event_in})) else $error("status bits wrong");
    read_answer_a: assert property (reg_rd_in |=> reg_rvalid_out &&
        reg_rdata_out == ($past(reg_addr_in) == BFIM_STATUS_ADDR ? $past(status_out) : 8'h00))
        else $error("read answer wrong");
    keypad_first_a: assert property (!$past(sys_rst_in)
        |-> ((ball_oe_n_out ^ ~$past(keypad_oe_in)) & $past(keypad_claim_in)) == 20'h00000)
        else $error("keypad ball not under keypad control");
endmodule : bfim_top_sva
bind bfim_top bfim_top_sva u_sva (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .supply_fail_in(supply_fail_in), .kbd_event_in(kbd_event_in),
    .countdown_event_in(countdown_event_in), .cycle_event_in(cycle_event_in),
    .gio_event_in(gio_event_in), .keypad_claim_in(keypad_claim_in),
    .keypad_oe_in(keypad_oe_in), .ball_out(ball_out), .ball_oe_n_out(ball_oe_n_out),
    .status_out(status_out));

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench
    import bfim_pkg::*;
;
    logic        mclk_in, sys_rst_in, reg_wr, reg_rd, rvalid, supply_fail, kbd_ev, gio_ev;
    logic [2:0]  cd_ev, cy_ev, dimmer;
    logic [7:0]  reg_addr, reg_wdata, rdata, status;
    logic [19:0] claim, kp_drive, kp_oe, g_drive, g_oe, ext_lvl, ball_w, b_out, b_oe_n;
    logic [19:0] g_sense, k_sense;
    int          n_mismatch, comparisons;
    assign ball_w = (~b_oe_n & b_out) | (b_oe_n & ext_lvl);
    always #10 mclk_in = ~mclk_in;
    bfim_top u_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr),
        .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .supply_fail_in(supply_fail),
        .kbd_event_in(kbd_ev), .countdown_event_in(cd_ev), .cycle_event_in(cy_ev),
        .gio_event_in(gio_ev), .keypad_claim_in(claim), .keypad_drive_in(kp_drive),
        .keypad_oe_in(kp_oe), .gpio_drive_in(g_drive), .gpio_oe_in(g_oe),
        .dimmer_in(dimmer), .ball_in(ball_w), .ball_out(b_out), .ball_oe_n_out(b_oe_n),
        .gpio_sense_out(g_sense), .keypad_sense_out(k_sense), .status_out(status));
    bfim_host_model u_host (.mclk_in(mclk_in), .reg_addr_out(reg_addr), .reg_wr_out(reg_wr),
        .reg_wdata_out(reg_wdata), .reg_rd_out(reg_rd), .reg_rdata_in(rdata),
        .reg_rvalid_in(rvalid));
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : step
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk_byte
    task automatic chk_ball(input string nm, input logic [19:0] e, input logic [19:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk_ball
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.read_reg(a, d);
        chk_byte(nm, e, d);
    endtask : rd_chk
    task automatic final_report;
        $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic t_boot;
        rd_chk("status_rst", BFIM_STATUS_ADDR, 8'h80);
        u_host.write_reg(BFIM_CLEAR_ADDR, 8'hFE);
        rd_chk("clear_zero", BFIM_STATUS_ADDR, 8'h80);
        u_host.boot();
        rd_chk("status_clr", BFIM_STATUS_ADDR, 8'h00);
        rd_chk("map_wo", BFIM_MAP_ADDR, 8'h00);
        rd_chk("unmapped", 8'h3C, 8'h00);
        chk_ball("oe_n_rst", 20'hFFFFF, b_oe_n);
    endtask : t_boot
    task automatic t_events;
        logic [7:0] e;
        for (int j = 0; j < 9; j++)
        begin
            {kbd_ev, cy_ev, cd_ev, gio_ev} = (j == 8) ? 8'hFF : 8'h01 << j;
            e = (j == 8) ? 8'h4F : (j == 7) ? 8'h40 : (j > 3) ? 8'h01 << (j - 3) : 8'h01 << j;
            rd_chk("status_ev", BFIM_STATUS_ADDR, e);
            chk_byte("status_port", e, status);
        end
        {kbd_ev, cy_ev, cd_ev, gio_ev} = 8'h00;
    endtask : t_events
    task automatic t_supply;
        supply_fail = 1'b1;
        step(5);
        supply_fail = 1'b0;
        rd_chk("supply_set", BFIM_STATUS_ADDR, 8'h80);
        u_host.write_reg(BFIM_CLEAR_ADDR, 8'h01);
        rd_chk("supply_clr", BFIM_STATUS_ADDR, 8'h00);
        sys_rst_in = 1'b1;
        step(2);
        sys_rst_in = 1'b0;
        rd_chk("rerst", BFIM_STATUS_ADDR, 8'h80);
        chk_byte("status_port_rst", 8'h80, status);
        u_host.boot();
    endtask : t_supply
    task automatic t_irq;
        // unused bits 7:5 set on purpose, they must not disturb the ball
        u_host.write_reg(BFIM_MAP_ADDR, 8'hF0);
        step(2);
        chk_ball("req_idle", 20'hFFFFF, b_oe_n);
        gio_ev = 1'b1;
        step(3);
        chk_ball("req_on", 20'h7FFFF, b_oe_n);
        chk_ball("req_low", 20'h00000, b_out & ~b_oe_n);
        gio_ev = 1'b0;
        step(3);
        chk_ball("req_off", 20'hFFFFF, b_oe_n);
    endtask : t_irq
    task automatic map_case(input logic [7:0] w, input logic [3:0] oe, input logic [3:0] lv);
        u_host.write_reg(BFIM_MAP_ADDR, w);
        step(2);
        chk_ball("map_oe_n", {oe, 16'h0000}, b_oe_n);
        chk_ball("map_out", {lv, 16'hA5A5}, b_out & ~b_oe_n);
    endtask : map_case
    task automatic t_map;
        {g_oe, g_drive, dimmer} = {20'hFFFFF, 20'h5A5A5, 3'b011};
        map_case(8'h00, 4'h0, 4'h5);
        step(2);
        chk_ball("gio_sense", 20'h5A5A5, g_sense);
        map_case(8'h01, 4'h1, 4'h6);
        map_case(8'h11, 4'h8, 4'h6);
        map_case(8'h02, 4'h7, 4'h0);
        // column 3 is not a valid option, the previous column stays
        map_case(8'h03, 4'h7, 4'h0);
        g_oe = 20'h00000;
    endtask : t_map
    task automatic t_keypad;
        {claim, kp_oe, kp_drive, ext_lvl} = {20'hFFFFF, 20'h0F0F0, 20'h33333, 20'hC9A36};
        step(4);
        chk_ball("kp_oe_n", 20'hF0F0F, b_oe_n);
        chk_ball("kp_out", 20'h03030, b_out & ~b_oe_n);
        chk_ball("kp_sense", 20'hC3A36, k_sense);
        chk_ball("gio_sense_kp", 20'h00000, g_sense);
        claim = 20'h00000;
    endtask : t_keypad
    initial
    begin
        {mclk_in, sys_rst_in, supply_fail, kbd_ev, gio_ev} = 5'b01000;
        {cd_ev, cy_ev, dimmer} = 9'h000;
        {claim, kp_drive, kp_oe, g_drive, g_oe, ext_lvl} = 120'h0;
        {n_mismatch, comparisons} = 64'h0;
        step(8);
        sys_rst_in = 1'b0;
        t_boot();
        t_events();
        t_supply();
        t_irq();
        t_map();
        t_keypad();
        final_report();
    end
    initial
    begin
        #40000;
        n_mismatch++;
        final_report();
    end
endmodule : testbench

// file: src/bfim_ball_route.sv
`timescale 1ns/1ps
module bfim_ball_route
    import bfim_pkg::*;
(
    input  wire logic        mclk_in,             // system clock
    input  wire logic        sys_rst_in,          // sync reset, active high
    input  wire logic [19:0] claim_in,            // keypad claims ball
    input  wire logic [2:0]  col_in,              // applied option column
    input  wire logic        req_sel_in,          // column 11 is request ball
    input  wire logic        irq_assert_in,       // request should be active
    input  wire logic [19:0] ball_sync_in,        // synchronised ball levels
    input  wire logic [19:0] gpio_drive_in,       // general I/O output data
    input  wire logic [19:0] gpio_oe_in,          // general I/O drive enable
    input  wire logic [19:0] keypad_drive_in,     // keypad output data
    input  wire logic [19:0] keypad_oe_in,        // keypad drive enable
    input  wire logic [2:0]  dimmer_in,           // dimmer outputs 0..2
    output logic      [19:0] ball_out,            // ball output level
    output logic      [19:0] ball_oe_n_out,       // low while driving
    output logic      [19:0] gpio_sense_out,      // ball level to general I/O
    output logic      [19:0] keypad_sense_out     // ball level to keypad
);

    typedef struct packed {
        logic [19:0] out;
        logic [19:0] oe_n;
        logic [19:0] gsense;
        logic [19:0] ksense;
    } bfim_route_t;

    bfim_route_t r_q;
    bfim_route_t r_d;

    always_comb
    begin
        r_d = r_q;
        for (int i = 0; i < BFIM_BALLS; i++)
        begin
            r_d.out[i]    = 1'b0;
            r_d.oe_n[i]   = 1'b1;
            r_d.gsense[i] = 1'b0;
            r_d.ksense[i] = 1'b0;
            case (bfim_ball_fn(i, claim_in[i], col_in, req_sel_in))
                BFIM_FN_KEYPAD:
                begin
                    r_d.out[i]    = keypad_drive_in[i];
                    r_d.oe_n[i]   = ~keypad_oe_in[i];
                    r_d.ksense[i] = ball_sync_in[i];
                end
                BFIM_FN_GPIO:
                begin
                    r_d.out[i]    = gpio_drive_in[i];
                    r_d.oe_n[i]   = ~gpio_oe_in[i];
                    r_d.gsense[i] = ball_sync_in[i];
                end
                BFIM_FN_DIMMER:
                begin
                    r_d.out[i]  = dimmer_in[bfim_dimmer_idx(i)];
                    r_d.oe_n[i] = 1'b0;
                end
                BFIM_FN_IRQ:
                begin
                    // open drain: pull low when pending, otherwise release
                    r_d.out[i]  = 1'b0;
                    r_d.oe_n[i] = ~irq_assert_in;
                end
                default:
                begin
                    r_d.out[i]  = 1'b0;
                    r_d.oe_n[i] = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            r_q.out    <= 20'h00000;
            r_q.oe_n   <= 20'hFFFFF;
            r_q.gsense <= 20'h00000;
            r_q.ksense <= 20'h00000;
        end
        else
            r_q <= r_d;
    end

    assign ball_out         = r_q.out;
    assign ball_oe_n_out    = r_q.oe_n;
    assign gpio_sense_out   = r_q.gsense;
    assign keypad_sense_out = r_q.ksense;

endmodule : bfim_ball_route

// file: src/bfim_pkg.sv
package bfim_pkg;

    // register port addresses
    localparam logic [7:0] BFIM_STATUS_ADDR    = 8'h91;
    localparam logic [7:0] BFIM_MAP_ADDR       = 8'hA7;
    localparam logic [7:0] BFIM_CLEAR_ADDR     = 8'h84;

    // global_interrupt_status bit positions
    localparam int         BFIM_SUPPLY_BIT     = 7;
    localparam int         BFIM_KBD_BIT        = 6;
    localparam int         BFIM_TIM2_BIT       = 3;
    localparam int         BFIM_TIM1_BIT       = 2;
    localparam int         BFIM_TIM0_BIT       = 1;
    localparam int         BFIM_GIO_BIT        = 0;
    localparam logic [7:0] BFIM_STATUS_USED    = 8'hCF;
    localparam logic [7:0] BFIM_STATUS_RST     = 8'h80;
    localparam logic       BFIM_SUPPLY_RST     = 1'b1;

    // reset_interrupt_clear field
    localparam int         BFIM_CLEAR_BIT      = 0;

    // ball_mapping_config fields
    localparam int         BFIM_REQ_SEL_BIT    = 4;
    localparam int         BFIM_COL_LSB        = 0;
    localparam int         BFIM_COL_W          = 3;
    localparam logic [2:0] BFIM_COL_GPIO       = 3'h0;
    localparam logic [2:0] BFIM_COL_DIMMER     = 3'h1;
    localparam logic [2:0] BFIM_COL_ALT        = 3'h2;
    localparam logic [2:0] BFIM_COL_RST        = 3'h0;
    localparam logic       BFIM_REQ_SEL_RST    = 1'b0;

    // balls: rows 0-7 are indices 0-7, columns 0-11 are indices 8-19
    localparam int         BFIM_BALLS          = 20;
    localparam int         BFIM_COL8_IDX       = 16;
    localparam int         BFIM_COL9_IDX       = 17;
    localparam int         BFIM_COL10_IDX      = 18;
    localparam int         BFIM_COL11_IDX      = 19;

    typedef enum {
        BFIM_FN_KEYPAD,
        BFIM_FN_GPIO,
        BFIM_FN_DIMMER,
        BFIM_FN_IRQ,
        BFIM_FN_IDLE
    } bfim_fn_t;

    // function of one ball from the keypad claim and the mapping config
    function automatic bfim_fn_t bfim_ball_fn(input int idx, input logic claim,
                                              input logic [2:0] col, input logic req_sel);
        bfim_fn_t fn;
        fn = BFIM_FN_GPIO;
        if (claim)
            fn = BFIM_FN_KEYPAD;
        else if (idx == BFIM_COL11_IDX)
        begin
            if (req_sel)
                fn = BFIM_FN_IRQ;
            else if (col != BFIM_COL_GPIO)
                fn = BFIM_FN_DIMMER;
        end
        else if (idx == BFIM_COL8_IDX)
        begin
            // dimmer two lives here only while column 11 carries the request
            if (col == BFIM_COL_DIMMER)
                fn = req_sel ? BFIM_FN_DIMMER : BFIM_FN_IDLE;
            else if (col == BFIM_COL_ALT)
                fn = BFIM_FN_IDLE;
        end
        else if (idx >= BFIM_COL9_IDX)
        begin
            if (col == BFIM_COL_DIMMER)
                fn = BFIM_FN_DIMMER;
            else if (col == BFIM_COL_ALT)
                fn = BFIM_FN_IDLE;
        end
        return fn;
    endfunction : bfim_ball_fn

    // which dimmer output an upper column ball carries
    function automatic int bfim_dimmer_idx(input int idx);
        int d;
        d = 2;
        if (idx == BFIM_COL9_IDX)
            d = 1;
        else if (idx == BFIM_COL10_IDX)
            d = 0;
        return d;
    endfunction : bfim_dimmer_idx

endpackage : bfim_pkg

// file: src/bfim_status_flags.sv
`timescale 1ns/1ps
module bfim_status_flags
    import bfim_pkg::*;
(
    input  wire logic       mclk_in,          // system clock
    input  wire logic       sys_rst_in,       // sync reset, active high
    input  wire logic       supply_fail_in,   // synchronised supply failure level
    input  wire logic       clear_in,         // clear pulse for supply flag
    input  wire logic       kbd_event_in,     // keyboard module pending
    input  wire logic [2:0] countdown_in,     // timer countdown events
    input  wire logic [2:0] cycle_in,         // timer cycle events
    input  wire logic       gio_event_in,     // general I/O module pending
    output logic      [7:0] status_out,       // global_interrupt_status
    output logic            any_out           // any status bit set
);

    typedef struct packed {
        logic       supply;
        logic [7:0] status;
    } bfim_flags_t;

    bfim_flags_t s_q;
    bfim_flags_t s_d;

    always_comb
    begin
        s_d = s_q;
        // a failure in the clearing cycle keeps the flag set
        s_d.supply = supply_fail_in | (s_q.supply & ~clear_in);
        s_d.status = 8'h00;
        s_d.status[BFIM_SUPPLY_BIT] = s_d.supply;
        s_d.status[BFIM_KBD_BIT]    = kbd_event_in;
        s_d.status[BFIM_TIM2_BIT]   = countdown_in[2] | cycle_in[2];
        s_d.status[BFIM_TIM1_BIT]   = countdown_in[1] | cycle_in[1];
        s_d.status[BFIM_TIM0_BIT]   = countdown_in[0] | cycle_in[0];
        s_d.status[BFIM_GIO_BIT]    = gio_event_in;
        s_d.status = s_d.status & BFIM_STATUS_USED;
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            s_q.supply <= BFIM_SUPPLY_RST;
            s_q.status <= BFIM_STATUS_RST;
        end
        else
            s_q <= s_d;
    end

    assign status_out = s_q.status;
    assign any_out    = |s_q.status;

endmodule : bfim_status_flags

// file: src/bfim_top.sv
// How it works
// - the request ball is pulled to its active low level while any status bit is set and it is configured as request.
// - the supply failure flag (bit 7) is set by reset itself and by any later supply failure.
// - a set supply failure flag tells the host the device was fully reset and needs reloading.
// - bit 6 mirrors the keyboard module's pending event and resets to 0.
// - bits 3, 2, 1 show countdown or cycle expiry of timers 2, 1, 0 and reset to 0.
// - bit 0 mirrors the general I/O module's pending event and resets to 0.
// - every ball is general I/O, dimmer, request or idle unless the keypad claims it, keypad first.
// - keypad size and dedicated key claims override the mapping register for affected balls.
// - the mapping register at 0xA7 is write only and acts only on balls the keypad leaves free.
// - column 0 gives general I/O 0-19, column 1 gives dimmers 1, 0 on upper balls 9-10 and dimmer 2 on ball 8 or ball 11.
// - dimmer two is on ball 8 or on ball 11, never both, chosen by mapping bit 4.
// - mapping bits 7:4 set up ball 11, bit 4 enables its request use, bits 7:5 unused.
// - each mapping write applies the option column held in its bits 2:0 if it is 0 to 2, otherwise the old column stays.
// - writing 1 to bit 0 of the clear register clears the supply flag, writing 0 does nothing.
`timescale 1ns/1ps
module bfim_top
    import bfim_pkg::*;
(
    input  wire logic        mclk_in,            // 50 MHz system clock
    input  wire logic        sys_rst_in,         // sync reset, active high
    input  wire logic [7:0]  reg_addr_in,        // register address
    input  wire logic        reg_wr_in,          // write strobe
    input  wire logic [7:0]  reg_wdata_in,       // write data
    input  wire logic        reg_rd_in,          // read strobe
    output logic      [7:0]  reg_rdata_out,      // read data
    output logic             reg_rvalid_out,     // read data valid pulse
    input  wire logic        supply_fail_in,     // async supply failure level
    input  wire logic        kbd_event_in,       // keyboard pending
    input  wire logic [2:0]  countdown_event_in, // timer countdown events
    input  wire logic [2:0]  cycle_event_in,     // timer cycle events
    input  wire logic        gio_event_in,       // general I/O pending
    input  wire logic [19:0] keypad_claim_in,    // balls claimed by keypad
    input  wire logic [19:0] keypad_drive_in,    // keypad output data
    input  wire logic [19:0] keypad_oe_in,       // keypad drive enable
    input  wire logic [19:0] gpio_drive_in,      // general I/O output data
    input  wire logic [19:0] gpio_oe_in,         // general I/O drive enable
    input  wire logic [2:0]  dimmer_in,          // dimmer outputs 0..2
    input  wire logic [19:0] ball_in,            // ball pin levels
    output logic      [19:0] ball_out,           // ball output level
    output logic      [19:0] ball_oe_n_out,      // low while driving
    output logic      [19:0] gpio_sense_out,     // ball level to general I/O
    output logic      [19:0] keypad_sense_out,   // ball level to keypad
    output logic      [7:0]  status_out          // status byte to host logic
);

    typedef struct packed {
        logic        fail_meta;
        logic        fail_sync;
        logic [19:0] ball_meta;
        logic [19:0] ball_sync;
        logic [2:0]  col;
        logic        req_sel;
        logic [7:0]  rdata;
        logic        rvalid;
    } bfim_top_t;

    bfim_top_t t_q;
    bfim_top_t t_d;
    logic [7:0] status;
    logic       any_set;
    logic       clear_hit;

    // clear only on a write of 1 to the clear bit
    assign clear_hit = reg_wr_in & (reg_addr_in == BFIM_CLEAR_ADDR)
                       & reg_wdata_in[BFIM_CLEAR_BIT];

    always_comb
    begin
        t_d = t_q;
        t_d.fail_meta = supply_fail_in;
        t_d.fail_sync = t_q.fail_meta;
        t_d.ball_meta = ball_in;
        t_d.ball_sync = t_q.ball_meta;
        t_d.rvalid    = 1'b0;
        if (reg_wr_in && reg_addr_in == BFIM_MAP_ADDR)
        begin
            t_d.req_sel = reg_wdata_in[BFIM_REQ_SEL_BIT];
            // columns past 2 hold no assignment, so the old one is kept
            if (reg_wdata_in[BFIM_COL_LSB +: BFIM_COL_W] <= BFIM_COL_ALT)
                t_d.col = reg_wdata_in[BFIM_COL_LSB +: BFIM_COL_W];
        end
        if (reg_rd_in)
        begin
            t_d.rvalid = 1'b1;
            // the mapping register is write only and reads as zero
            t_d.rdata  = (reg_addr_in == BFIM_STATUS_ADDR) ? status : 8'h00;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            t_q.fail_meta <= 1'b0;
            t_q.fail_sync <= 1'b0;
            t_q.ball_meta <= 20'h00000;
            t_q.ball_sync <= 20'h00000;
            t_q.col       <= BFIM_COL_RST;
            t_q.req_sel   <= BFIM_REQ_SEL_RST;
            t_q.rdata     <= 8'h00;
            t_q.rvalid    <= 1'b0;
        end
        else
            t_q <= t_d;
    end

    bfim_status_flags u_flags (
        .mclk_in        (mclk_in),
        .sys_rst_in     (sys_rst_in),
        .supply_fail_in (t_q.fail_sync),
        .clear_in       (clear_hit),
        .kbd_event_in   (kbd_event_in),
        .countdown_in   (countdown_event_in),
        .cycle_in       (cycle_event_in),
        .gio_event_in   (gio_event_in),
        .status_out     (status),
        .any_out        (any_set)
    );

    bfim_ball_route u_route (
        .mclk_in              (mclk_in),
        .sys_rst_in           (sys_rst_in),
        .claim_in             (keypad_claim_in),
        .col_in               (t_q.col),
        .req_sel_in           (t_q.req_sel),
        .irq_assert_in        (any_set),
        .ball_sync_in         (t_q.ball_sync),
        .gpio_drive_in        (gpio_drive_in),
        .gpio_oe_in           (gpio_oe_in),
        .keypad_drive_in      (keypad_drive_in),
        .keypad_oe_in         (keypad_oe_in),
        .dimmer_in            (dimmer_in),
        .ball_out             (ball_out),
        .ball_oe_n_out        (ball_oe_n_out),
        .gpio_sense_out       (gpio_sense_out),
        .keypad_sense_out     (keypad_sense_out)
    );

    assign reg_rdata_out  = t_q.rdata;
    assign reg_rvalid_out = t_q.rvalid;
    assign status_out     = status;

endmodule : bfim_top
